/* File: design/ccm_top.sv */
// Purpose: module configuration and pin drive-strength register bank
// Assumes: plain register port, read data one cycle after the read strobe
// Notes: protocol engine events arrive as same-clock pulses
//
// Contract
// R1: setting setup bit with other changes updates only the setup bit
// R2: clearing setup bit applies all other field changes in the same write
// R3: setting setup bit enters configuration at once, aborting traffic and sync
// R4: clearing setup bit resumes normal operation; bit reads state
// R5: after reset state is configuration, primary register reads 0x8000
// R6: setting halt bit enters diagnosis stop at once, aborting traffic and sync
// R7: clearing halt bit moves to configuration; bit reads halt state
// R8: driver type bits 4:3 encode line coding; writable only in configuration
// R9: node synchronised flag set in idle time before entering normal state
// R10: flag cleared before passive or halt on correction or counter errors
// R11: bit 6 selects whether sync frames must pass the filters
// R12: bits 8 and 9 enable channels A and B; configuration-only
// R13: secondary bit 2 enables media access test; configuration-only
// R14: secondary bit 4 sets guardian expected open in symbol window
// R15: secondary bit 5 sets guardian expected open in dynamic segment
// R16: secondary bit 6 enables external clock sync; configuration-only
// R17: coldstart inhibit bit 8 stops coldstart initiation; configuration-only
// R18: clock errors to red go halt if bit 9 set, else configuration
// R19: yellow to green allowed only when bit 10 set
// R20: drive register bits 0 to 5 pick partial drive when set; reset zero
// R21: configuration-only fields ignore writes outside configuration
//
// Chosen here: the plain strobed port.
`timescale 1ns/1ps
module ccm_top (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [ccm_pkg::ADDR_W-1:0] addr,
	input wire logic [ccm_pkg::DATA_W-1:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [ccm_pkg::DATA_W-1:0] rdata,
	input wire logic evt_sync_gain,
	input wire logic evt_sync_loss,
	input wire logic evt_clk_err_red,
	input wire logic engine_busy,
	input wire logic sync_filt_pass,
	input wire logic ext_sync_pin,
	output ccm_pkg::ccm_cfg_t cfg,
	output logic abort_q,
	output logic cfg_state_q,
	output logic halt_state_q,
	output logic coldstart_ok_q,
	output logic sync_frame_use_q,
	output logic y2g_ok_q,
	output logic ext_sync_q,
	output logic [5:0] partial_drive_q
);
	// ****************************
	// address decode
	// ****************************
	logic [ccm_pkg::ADDR_W-1:0] a_pri;
	logic [ccm_pkg::ADDR_W-1:0] a_sec;
	logic [ccm_pkg::ADDR_W-1:0] a_drv;
	assign a_pri = ccm_pkg::ADDR_W'({ccm_pkg::IDX_CFG_PRI, 2'b00});
	assign a_sec = ccm_pkg::ADDR_W'({ccm_pkg::IDX_CFG_SEC, 2'b00});
	assign a_drv = ccm_pkg::ADDR_W'({ccm_pkg::IDX_DRIVE, 2'b00});
	wire hit_pri = (addr == a_pri);
	wire hit_sec = (addr == a_sec);
	wire hit_drv = (addr == a_drv);
	wire wr_pri = wr && hit_pri;
	wire wr_sec = wr && hit_sec;
	wire wr_drv = wr && hit_drv;

	// ****************************
	// operating state
	// ****************************
	ccm_pkg::ccm_state_t st_q;
	ccm_pkg::ccm_state_t st_d;
	logic node_synchronised_flag_q;
	logic node_synchronised_flag_d;
	wire in_cfg = (st_q == ccm_pkg::ST_CONFIG);
	wire cur_setup = in_cfg;
	wire set_setup = wr_pri && wdata[ccm_pkg::B_SETUP] && !cur_setup;
	wire clr_setup = wr_pri && !wdata[ccm_pkg::B_SETUP] && cur_setup;
	wire set_halt = wr_pri && wdata[ccm_pkg::B_HALT] && !set_setup;
	wire clr_halt = wr_pri && !wdata[ccm_pkg::B_HALT] && (st_q == ccm_pkg::ST_HALT) && !set_setup;

	// primary write mask: setup-set write touches only the setup bit
	logic [15:0] pri_mask;
	assign pri_mask = set_setup ? (16'h0001 << ccm_pkg::B_SETUP) : // [R1]
		(in_cfg ? ccm_pkg::MASK_PRI : (ccm_pkg::MASK_PRI & ~ccm_pkg::MASK_PRI_CFGONLY)); // [R2] [R21]
	logic [15:0] sec_mask;
	assign sec_mask = in_cfg ? ccm_pkg::MASK_SEC : 16'h0000; // [R13] [R16] [R17] [R21]

	// state transitions; host writes take priority over engine events
	always_comb begin
		st_d = st_q;
		if (set_setup) begin
			st_d = ccm_pkg::ST_CONFIG; // [R3]
		end else if (set_halt) begin
			st_d = ccm_pkg::ST_HALT; // [R6]
		end else if (clr_halt) begin
			st_d = ccm_pkg::ST_CONFIG; // [R7]
		end else if (clr_setup) begin
			st_d = ccm_pkg::ST_NORMAL; // [R2] [R4]
		end else if (evt_clk_err_red && st_q == ccm_pkg::ST_NORMAL) begin
			st_d = cfg.allow_red ? ccm_pkg::ST_HALT : ccm_pkg::ST_CONFIG; // [R18]
		end
	end

	// node sync flag: gain sets, loss or any next state but normal clears; a non-normal next state beats gain, gain beats loss
	always_comb begin
		node_synchronised_flag_d = node_synchronised_flag_q;
		if (st_d != ccm_pkg::ST_NORMAL) begin
			node_synchronised_flag_d = 1'b0; // [R3] [R6]
		end else if (evt_sync_gain) begin
			node_synchronised_flag_d = 1'b1; // [R9]
		end else if (evt_sync_loss) begin
			node_synchronised_flag_d = 1'b0; // [R10]
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			st_q <= ccm_pkg::ST_CONFIG; // [R5]
			node_synchronised_flag_q <= 1'b0;
		end else begin
			st_q <= st_d;
			node_synchronised_flag_q <= node_synchronised_flag_d;
		end
	end

	// ****************************
	// stored registers
	// ****************************
	logic [15:0] pri_q;
	logic [15:0] sec_q;
	logic [15:0] drv_q;
	// state-owned bits kept out of the stored copy
	ccm_wreg #(.W(16), .RST(ccm_pkg::RST_CFG_PRI & ~(16'h0001 << ccm_pkg::B_SETUP))) u_pri (
		.clk(clk),
		.rst_b(rst_b),
		.we(wr_pri),
		.mask(pri_mask & ~(16'h0001 << ccm_pkg::B_SETUP) & ~(16'h0001 << ccm_pkg::B_HALT)),
		.wdata(wdata),
		.q(pri_q)
	);
	ccm_wreg #(.W(16), .RST(ccm_pkg::RST_CFG_SEC)) u_sec (
		.clk(clk),
		.rst_b(rst_b),
		.we(wr_sec),
		.mask(sec_mask),
		.wdata(wdata),
		.q(sec_q)
	);
	ccm_wreg #(.W(16), .RST(ccm_pkg::RST_DRIVE)) u_drv (
		.clk(clk),
		.rst_b(rst_b),
		.we(wr_drv),
		.mask(ccm_pkg::MASK_DRIVE), // [R20]
		.wdata(wdata),
		.q(drv_q)
	);

	// ****************************
	// read view and read port
	// ****************************
	logic [15:0] pri_view;
	assign pri_view = (pri_q & ccm_pkg::MASK_PRI)
		| (16'(in_cfg) << ccm_pkg::B_SETUP) // [R4]
		| (16'(st_q == ccm_pkg::ST_HALT) << ccm_pkg::B_HALT) // [R7]
		| (16'(node_synchronised_flag_q) << ccm_pkg::B_NODE_SYNCHRONISED_FLAG);
	logic [15:0] rd_mux;
	assign rd_mux = hit_pri ? pri_view :
		hit_sec ? (sec_q & ccm_pkg::MASK_SEC) :
		hit_drv ? (drv_q & ccm_pkg::MASK_DRIVE) : 16'h0000; // unmapped reads zero
	logic [15:0] rdata_q;
	// read data valid only in the cycle after the strobe
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rdata_q <= 16'h0000;
		end else begin
			rdata_q <= rd ? rd_mux : 16'h0000;
		end
	end
	assign rdata = rdata_q;

	// ****************************
	// configuration outputs
	// ****************************
	logic ext_pin_s;
	ccm_sync2 #(.W(1)) u_ext (
		.clk(clk),
		.rst_b(rst_b),
		.din(ext_sync_pin),
		.dout(ext_pin_s)
	);
	ccm_pkg::ccm_cfg_t cfg_d;
	assign cfg_d.chan_a_en = pri_q[ccm_pkg::B_CHA]; // [R12]
	assign cfg_d.chan_b_en = pri_q[ccm_pkg::B_CHB]; // [R12]
	assign cfg_d.drv_type = pri_q[ccm_pkg::B_DRV_HI:ccm_pkg::B_DRV_LO]; // [R8]
	assign cfg_d.sync_filt_en = pri_q[ccm_pkg::B_SYNFILT];
	assign cfg_d.mat_en = sec_q[ccm_pkg::B_MEDIA_ACCESS_TEST_ENABLE];
	assign cfg_d.swin_open = sec_q[ccm_pkg::B_SWIN]; // [R14]
	assign cfg_d.dseg_open = sec_q[ccm_pkg::B_DSEG]; // [R15]
	assign cfg_d.ext_sync_en = sec_q[ccm_pkg::B_EXTERNAL_CLOCK_SYNC_ENABLE];
	assign cfg_d.coldstart_inh = sec_q[ccm_pkg::B_CSI];
	assign cfg_d.allow_red = sec_q[ccm_pkg::B_ARL];
	assign cfg_d.allow_y2g = sec_q[ccm_pkg::B_ALLOW_YELLOW_TO_GREEN];

	// aborting traffic is a one-cycle pulse when setup or halt is set or normal is left, only while engine_busy
	wire leaving_normal = (st_q == ccm_pkg::ST_NORMAL) && (st_d != ccm_pkg::ST_NORMAL);
	wire abort_d = (set_setup || set_halt || leaving_normal) && engine_busy; // [R3] [R6]
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cfg <= '0;
			abort_q <= 1'b0;
			cfg_state_q <= 1'b1;
			halt_state_q <= 1'b0;
			coldstart_ok_q <= 1'b0;
			sync_frame_use_q <= 1'b0;
			y2g_ok_q <= 1'b0;
			ext_sync_q <= 1'b0;
			partial_drive_q <= 6'h00;
		end else begin
			cfg <= cfg_d;
			abort_q <= abort_d;
			cfg_state_q <= (st_d == ccm_pkg::ST_CONFIG);
			halt_state_q <= (st_d == ccm_pkg::ST_HALT);
			coldstart_ok_q <= !cfg_d.coldstart_inh && (st_d == ccm_pkg::ST_NORMAL); // [R17]
			sync_frame_use_q <= !cfg_d.sync_filt_en || sync_filt_pass; // [R11]
			y2g_ok_q <= cfg_d.allow_y2g; // [R19]
			ext_sync_q <= cfg_d.ext_sync_en && ext_pin_s; // [R16]
			partial_drive_q <= drv_q[5:0]; // [R20]
		end
	end
endmodule : ccm_top

/* File: design/ccm_pkg.sv */
// Purpose: shared constants and types for the controller module configuration bank
// Assumes: 16-bit registers, byte offsets four times the printed values
// Notes: printed offsets, multiples of four included, are kept as register indices
package ccm_pkg;
	// register indices as printed; byte address is four times the index
	localparam logic [7:0] IDX_CFG_PRI = 8'h04;
	localparam logic [7:0] IDX_CFG_SEC = 8'h06;
	localparam logic [7:0] IDX_DRIVE = 8'h9A;
	localparam logic [7:0] IDX_ENGINE_EVT = 8'hF0;
	localparam int ADDR_W = 10;
	localparam int DATA_W = 16;
	localparam logic [15:0] RST_CFG_PRI = 16'h8000;
	localparam logic [15:0] RST_CFG_SEC = 16'h0000;
	localparam logic [15:0] RST_DRIVE = 16'h0000;
	// field positions, primary register
	localparam int B_SETUP = 15;
	localparam int B_CHB = 9;
	localparam int B_CHA = 8;
	localparam int B_SYNFILT = 6;
	localparam int B_NODE_SYNCHRONISED_FLAG = 5;
	localparam int B_DRV_HI = 4;
	localparam int B_DRV_LO = 3;
	localparam int B_HALT = 1;
	// field positions, secondary register
	localparam int B_ALLOW_YELLOW_TO_GREEN = 10;
	localparam int B_ARL = 9;
	localparam int B_CSI = 8;
	localparam int B_EXTERNAL_CLOCK_SYNC_ENABLE = 6;
	localparam int B_DSEG = 5;
	localparam int B_SWIN = 4;
	localparam int B_MEDIA_ACCESS_TEST_ENABLE = 2;
	// writable masks
	localparam logic [15:0] MASK_PRI = 16'h835A;
	localparam logic [15:0] MASK_PRI_CFGONLY = 16'h0318;
	localparam logic [15:0] MASK_SEC = 16'h0774;
	localparam logic [15:0] MASK_DRIVE = 16'h003F;
	// bus driver type encodings
	localparam logic [1:0] DRV_RS485_LO = 2'h0;
	localparam logic [1:0] DRV_PHY = 2'h1;
	localparam logic [1:0] DRV_UNUSED = 2'h2;
	localparam logic [1:0] DRV_RS485_HI = 2'h3;
	typedef enum {ST_CONFIG, ST_NORMAL, ST_HALT} ccm_state_t;
	// configuration handed to the protocol engine
	typedef struct packed {
		logic chan_a_en;
		logic chan_b_en;
		logic [1:0] drv_type;
		logic sync_filt_en;
		logic mat_en;
		logic swin_open;
		logic dseg_open;
		logic ext_sync_en;
		logic coldstart_inh;
		logic allow_red;
		logic allow_y2g;
	} ccm_cfg_t;
	// events reported by the protocol engine
	typedef struct packed {
		logic sync_gain;
		logic sync_loss;
		logic clk_err_red;
	} ccm_evt_t;
endpackage : ccm_pkg

/* File: design/ccm_wreg.sv */
// Purpose: one 16-bit register with per-bit write mask
// Assumes: asynchronous active-low reset to a constant
// Notes: write applies only masked bits
`timescale 1ns/1ps
module ccm_wreg #(
	parameter int W = 16,
	parameter logic [15:0] RST = 16'h0000
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic we,
	input wire logic [W-1:0] mask,
	input wire logic [W-1:0] wdata,
	output logic [W-1:0] q
);
	logic [W-1:0] reg_q;
	logic [W-1:0] reg_d;
	// ***************
	// bitwise masked update, one generate per bit
	// ***************
	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			assign reg_d[i] = (we && mask[i]) ? wdata[i] : reg_q[i];
		end
	endgenerate
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			reg_q <= RST[W-1:0];
		end else begin
			reg_q <= reg_d;
		end
	end
	assign q = reg_q;
endmodule : ccm_wreg

/* File: design/ccm_sync2.sv */
// Purpose: two-flop synchroniser for a level from outside the clock domain
// Assumes: single clock
// Notes: first flop is read only by the second
`timescale 1ns/1ps
module ccm_sync2 #(
	parameter int W = 1
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [W-1:0] din,
	output logic [W-1:0] dout
);
	logic [W-1:0] meta_q;
	logic [W-1:0] sync_q;
	// metastability guard
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			meta_q <= '0;
			sync_q <= '0;
		end else begin
			meta_q <= din;
			sync_q <= meta_q;
		end
	end
	assign dout = sync_q;
endmodule : ccm_sync2

/* File: testbench/ccm_chk.sv */
// Purpose: port-level assertions for the configuration register bank
// Assumes: single clock, read data stands only in the cycle after rd
// Notes: attached to ccm_top by bind at the foot of this file
`timescale 1ns/1ps
module ccm_chk (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [ccm_pkg::ADDR_W-1:0] addr,
	input wire logic [ccm_pkg::DATA_W-1:0] wdata,
	input wire logic wr,
	input wire logic rd,
	input wire logic [ccm_pkg::DATA_W-1:0] rdata,
	input wire logic evt_clk_err_red,
	input wire logic sync_filt_pass,
	input wire ccm_pkg::ccm_cfg_t cfg,
	input wire logic cfg_state_q,
	input wire logic halt_state_q,
	input wire logic sync_frame_use_q,
	input wire logic [5:0] partial_drive_q
);
	// ****************
	// state and fields
	// ****************
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	// setting setup touches nothing but the state
	// cfg trails the stored register by one edge, so fields are compared a cycle later
	a_setup_only: assert property (wr && addr == 10'h010 && wdata[15] && !cfg_state_q |=>
		cfg_state_q && !halt_state_q ##1 cfg == $past(cfg)) else $error("setup write changed fields");
	// locked fields survive any write outside configuration
	a_cfg_locked: assert property (wr && !cfg_state_q |=> ##1
		{cfg[11:8], cfg[6:0]} == $past({cfg[11:8], cfg[6:0]})) else $error("locked field moved");
	a_leave_cfg: assert property (wr && addr == 10'h010 && cfg_state_q && !wdata[15] && !wdata[1] |=>
		!cfg_state_q ##1 cfg.chan_a_en == $past(wdata[8], 2) && cfg.drv_type == $past(wdata[4:3], 2))
		else $error("clearing setup lost fields");
	a_halt_enter: assert property (wr && addr == 10'h010 && wdata[1] && !wdata[15] |=> halt_state_q)
		else $error("halt not entered");
	a_halt_leave: assert property (halt_state_q && wr && addr == 10'h010 && !wdata[1] |=> cfg_state_q)
		else $error("halt exit not to configuration");
	a_red_level: assert property (evt_clk_err_red && !cfg_state_q && !halt_state_q && !wr |=>
		halt_state_q == $past(cfg.allow_red) && cfg_state_q != $past(cfg.allow_red)) else $error("red path wrong");
	// first cycles after release are skipped: flops may still see reset there
	a_sync_use: assert property ($past(rst_b) |=>
		sync_frame_use_q == (!cfg.sync_filt_en || $past(sync_filt_pass))) else $error("sync use wrong");
	// read data show the state at the strobe, not the state after it
	a_state_read: assert property (rd && addr == 10'h010 |=>
		rdata[15] == $past(cfg_state_q) && rdata[1] == $past(halt_state_q)) else $error("state bits misread");
	a_drive_read: assert property (rd && addr == 10'h268 |=> rdata == {10'h000, partial_drive_q})
		else $error("drive read wrong");
endmodule : ccm_chk
bind ccm_top ccm_chk u_ccm_chk (.clk, .rst_b, .addr, .wdata, .wr, .rd, .rdata, .evt_clk_err_red,
	.sync_filt_pass, .cfg, .cfg_state_q, .halt_state_q, .sync_frame_use_q, .partial_drive_q);

/* File: testbench/ccm_eng_model.sv */
// Purpose: protocol engine stand-in driving events and levels
// Assumes: events are one-cycle pulses on the bank clock
// Notes: only the bench decides when an event fires
`timescale 1ns/1ps
module ccm_eng_model (
	input wire logic clk,
	output logic evt_sync_gain,
	output logic evt_sync_loss,
	output logic evt_clk_err_red,
	output logic engine_busy,
	output logic sync_filt_pass,
	output logic ext_sync_pin
);
	// quiet engine until told otherwise
	initial {evt_sync_gain, evt_sync_loss, evt_clk_err_red, engine_busy, sync_filt_pass, ext_sync_pin} = 6'h00;
	// one-cycle pulse, order gain, loss, red
	task automatic pulse(input logic [2:0] k);
		@(posedge clk);
		{evt_sync_gain, evt_sync_loss, evt_clk_err_red} <= k;
		@(posedge clk);
		{evt_sync_gain, evt_sync_loss, evt_clk_err_red} <= 3'h0;
	endtask : pulse
	// traffic, filter verdict and external sync pin levels
	task automatic level(input logic b, input logic p, input logic x);
		@(posedge clk);
		engine_busy <= b;
		sync_filt_pass <= p;
		ext_sync_pin <= x;
	endtask : level
endmodule : ccm_eng_model

/* File: testbench/tb_top.sv */
// Purpose: register-level tests of the configuration bank
// Assumes: byte addresses 0x010, 0x018, 0x268
// Notes: engine events come from the partner model
`timescale 1ns/1ps
module tb_top;
	logic clk = 1'b0, rst_b = 1'b0, wr = 1'b0, rd = 1'b0;
	logic [9:0] addr = 10'h000;
	logic [15:0] wdata = 16'h0000, rdata;
	logic evt_sync_gain, evt_sync_loss, evt_clk_err_red, engine_busy, sync_filt_pass, ext_sync_pin;
	logic abort_q, cfg_state_q, halt_state_q, coldstart_ok_q, sync_frame_use_q, y2g_ok_q, ext_sync_q;
	logic [5:0] partial_drive_q;
	ccm_pkg::ccm_cfg_t cfg;
	int fail_count = 0, cmp_count = 0;
	// 250 MHz
	always #2 clk = ~clk;
	ccm_top u_ccm_top (.clk, .rst_b, .addr, .wdata, .wr, .rd, .rdata, .evt_sync_gain, .evt_sync_loss,
		.evt_clk_err_red, .engine_busy, .sync_filt_pass, .ext_sync_pin, .cfg, .abort_q, .cfg_state_q,
		.halt_state_q, .coldstart_ok_q, .sync_frame_use_q, .y2g_ok_q, .ext_sync_q, .partial_drive_q);
	ccm_eng_model u_ccm_eng_model (.clk, .evt_sync_gain, .evt_sync_loss, .evt_clk_err_red, .engine_busy,
		.sync_filt_pass, .ext_sync_pin);
	// ****************
	// bus tasks
	// ****************
	task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
		cmp_count++;
		if (s !== e) begin
			fail_count++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	task automatic wreg(input logic [9:0] a, input logic [15:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask : wreg
	// data is looked at only in the cycle after the strobe
	task automatic rreg(input logic [9:0] a, input logic [15:0] e);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 chk("rdata", rdata, e);
	endtask : rreg
	task automatic complete_run;
		$display("comparisons %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : complete_run
	// hang guard
	initial begin
		repeat (20000) @(posedge clk);
		fail_count++;
		complete_run;
	end
	// ****************
	// sequence
	// ****************
	initial begin
		repeat (16) @(posedge clk);
		rst_b <= 1'b1;
		rreg(10'h010, 16'h8000);
		chk("y2g_ok_q", 16'(y2g_ok_q), 16'h0000);
		chk("ext_sync_q", 16'(ext_sync_q), 16'h0000);
		rreg(10'h018, 16'h0000);
		wreg(10'h268, 16'hFFFF);
		rreg(10'h268, 16'h003F);
		chk("partial_drive_q", 16'(partial_drive_q), 16'h003F);
		wreg(10'h020, 16'h1234);
		rreg(10'h020, 16'h0000);
		for (int c = 0; c < 4; c++) begin
			wreg(10'h010, 16'h8000 | 16'(c << 3));
			rreg(10'h010, 16'h8000 | 16'(c << 3));
		end
		wreg(10'h018, 16'h0774);
		rreg(10'h018, 16'h0774);
		chk("cfg", 16'(cfg), 16'h037F);
		$display("reset and configuration test done");
		wreg(10'h010, 16'h0358);
		rreg(10'h010, 16'h0358);
		chk("cfg", 16'(cfg), 16'h0FFF);
		wreg(10'h010, 16'h0000);
		rreg(10'h010, 16'h0318);
		wreg(10'h018, 16'h0000);
		rreg(10'h018, 16'h0774);
		u_ccm_eng_model.pulse(3'h4);
		rreg(10'h010, 16'h0338);
		u_ccm_eng_model.pulse(3'h2);
		rreg(10'h010, 16'h0318);
		chk("coldstart_ok_q", 16'(coldstart_ok_q), 16'h0000);
		chk("y2g_ok_q", 16'(y2g_ok_q), 16'h0001);
		u_ccm_eng_model.level(1'b1, 1'b0, 1'b1);
		wreg(10'h010, 16'h8040);
		#1 chk("abort_q", 16'(abort_q), 16'h0001);
		rreg(10'h010, 16'h8318);
		chk("ext_sync_q", 16'(ext_sync_q), 16'h0001);
		u_ccm_eng_model.level(1'b0, 1'b1, 1'b0);
		$display("normal operation test done");
		wreg(10'h010, 16'h031A);
		rreg(10'h010, 16'h031A);
		chk("ext_sync_q", 16'(ext_sync_q), 16'h0000);
		wreg(10'h010, 16'h0318);
		rreg(10'h010, 16'h8318);
		wreg(10'h010, 16'h0318);
		u_ccm_eng_model.pulse(3'h1);
		#1 chk("halt_state_q", 16'(halt_state_q), 16'h0001);
		wreg(10'h010, 16'h0318);
		// red level and coldstart inhibit both dropped
		wreg(10'h018, 16'h0474);
		wreg(10'h010, 16'h0318);
		#1 chk("coldstart_ok_q", 16'(coldstart_ok_q), 16'h0001);
		u_ccm_eng_model.pulse(3'h1);
		#1 chk("cfg_state_q", 16'(cfg_state_q), 16'h0001);
		wreg(10'h010, 16'h8358);
		u_ccm_eng_model.level(1'b0, 1'b0, 1'b0);
		u_ccm_eng_model.level(1'b0, 1'b1, 1'b0);
		#1 chk("sync_frame_use_q", 16'(sync_frame_use_q), 16'h0000);
		repeat (2) @(posedge clk);
		#1 chk("sync_frame_use_q", 16'(sync_frame_use_q), 16'h0001);
		$display("halt and error level test done");
		complete_run;
	end
endmodule : tb_top
